// file: dopwm_top.sv
`timescale 1ns/10ps
// Dual output pulse width modulator around one shared counter
module dopwm_top (
  input  wire logic        clk_i,                 // Core clock
  input  wire logic        arst_n_i,              // Async reset, low
  input  wire logic [1:0]  mode_i,                // Mode select field
  input  wire logic [7:0]  compare_a_high_byte_i, // Compare A high byte
  input  wire logic [7:0]  compare_a_low_byte_i,  // Compare A low byte
  input  wire logic [7:0]  compare_b_high_byte_i, // Compare B high byte
  input  wire logic [7:0]  compare_b_low_byte_i,  // Compare B low byte
  input  wire logic        port_a_do_i,           // Port data pin A
  input  wire logic        port_a_oe_i,           // Port enable pin A
  input  wire logic        port_b_do_i,           // Port data pin B
  input  wire logic        port_b_oe_i,           // Port enable pin B
  input  wire logic        port_pin_a_i,          // Pin A level in
  input  wire logic        port_pin_b_i,          // Pin B level in
  output logic             port_pin_a_o,          // Pin A level out
  output logic             port_pin_a_oe_o,       // Pin A drive enable
  output logic             port_pin_b_o,          // Pin B level out
  output logic             port_pin_b_oe_o,       // Pin B drive enable
  output logic             port_pin_a_sync_o,     // Pin A synchronised
  output logic             port_pin_b_sync_o,     // Pin B synchronised
  output logic [15:0]      count_o,               // Shared counter
  output logic             waveform_out_a_o,      // Waveform A
  output logic             waveform_out_b_o,      // Waveform B
  output logic             active_o               // Waveform mode on
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        wave_a;
    logic        wave_b;
    logic [1:0]  mode;
    logic [2:0]  sync_a;
    logic [2:0]  sync_b;
    logic        pin_a;
    logic        pin_b;
  } dopwm_state_s;

  dopwm_state_s           st_r;
  dopwm_state_s           st_nxt;
  dopwm_pkg::dopwm_mode_e mode_oh;
  logic [15:0]            cmp_a;
  logic [15:0]            cmp_b;
  logic                   wrap;
  logic                   restart;

  assign cmp_a = {compare_a_high_byte_i, compare_a_low_byte_i};
  assign cmp_b = {compare_b_high_byte_i, compare_b_low_byte_i};

  dopwm_mode_dec u_dec (
    .mode_i (st_r.mode),
    .mode_o (mode_oh)
  );

  // Counter end condition per mode
  always_comb begin
    case (mode_oh)
      dopwm_pkg::DOPWM_M_ONE:  wrap = (st_r.cnt >= cmp_b);
      dopwm_pkg::DOPWM_M_TWIN: wrap = (st_r.cnt[7:0] >= compare_b_low_byte_i);
      dopwm_pkg::DOPWM_M_FULL: wrap = (st_r.cnt == dopwm_pkg::CNT_MAX);
      default:                 wrap = 1'b1;
    endcase
  end

  // Next state; mode change restarts the period so outputs align
  always_comb begin
    st_nxt      = st_r;
    st_nxt.mode = mode_i;
    restart     = wrap || (mode_i != st_r.mode);
    st_nxt.cnt  = restart ? dopwm_pkg::CNT_RST : st_r.cnt + 16'h0001;
    case (mode_oh)
      // A zero duty keeps A low; the first count after a mode switch re-arms A
      dopwm_pkg::DOPWM_M_ONE: begin
        if (restart) begin
          st_nxt.wave_a = (cmp_a != 16'h0000);
        end else if (st_nxt.cnt == cmp_a) begin
          st_nxt.wave_a = 1'b0;
        end else if (st_r.cnt == dopwm_pkg::CNT_RST) begin
          st_nxt.wave_a = (cmp_a != 16'h0000);
        end
        st_nxt.wave_b = 1'b0;
      end
      dopwm_pkg::DOPWM_M_TWIN: begin
        if (restart) begin
          st_nxt.wave_a = (compare_a_low_byte_i != 8'h00);
        end else if (st_nxt.cnt[7:0] == compare_a_low_byte_i) begin
          st_nxt.wave_a = 1'b0;
        end else if (st_r.cnt == dopwm_pkg::CNT_RST) begin
          st_nxt.wave_a = (compare_a_low_byte_i != 8'h00);
        end
        // Fall checked before rise; equal bytes leave B low
        if (st_nxt.cnt[7:0] == compare_a_high_byte_i) begin
          st_nxt.wave_b = 1'b0;
        end else if (st_nxt.cnt[7:0] == compare_b_high_byte_i) begin
          st_nxt.wave_b = 1'b1;
        end
      end
      dopwm_pkg::DOPWM_M_FULL: begin
        st_nxt.wave_a = (st_nxt.cnt < cmp_a);
        st_nxt.wave_b = (st_nxt.cnt < cmp_b);
      end
      default: begin
        st_nxt.wave_a = 1'b0;
        st_nxt.wave_b = 1'b0;
      end
    endcase
    // Three-stage pin synchronisers, change taken when stages 2 and 3 agree
    st_nxt.sync_a = {st_r.sync_a[1:0], port_pin_a_i};
    st_nxt.sync_b = {st_r.sync_b[1:0], port_pin_b_i};
    if (st_r.sync_a[1] == st_r.sync_a[2]) begin
      st_nxt.pin_a = st_r.sync_a[2];
    end
    if (st_r.sync_b[1] == st_r.sync_b[2]) begin
      st_nxt.pin_b = st_r.sync_b[2];
    end
  end

  // Single state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // In mode 0 the pins fall back to the port logic
  dopwm_pin_mux u_mux_a (
    .pwm_en_i  (active_o),
    .wave_i    (st_r.wave_a),
    .port_do_i (port_a_do_i),
    .port_oe_i (port_a_oe_i),
    .pin_o     (port_pin_a_o),
    .pin_oe_o  (port_pin_a_oe_o)
  );

  // Pin B is a port pin in modes 0 and 1
  dopwm_pin_mux u_mux_b (
    .pwm_en_i  (st_r.mode[1]),
    .wave_i    (st_r.wave_b),
    .port_do_i (port_b_do_i),
    .port_oe_i (port_b_oe_i),
    .pin_o     (port_pin_b_o),
    .pin_oe_o  (port_pin_b_oe_o)
  );

  assign active_o          = (st_r.mode != dopwm_pkg::MODE_OFF);
  assign count_o           = st_r.cnt;
  assign waveform_out_a_o  = st_r.wave_a;
  assign waveform_out_b_o  = st_r.wave_b;
  assign port_pin_a_sync_o = st_r.pin_a;
  assign port_pin_b_sync_o = st_r.pin_b;

endmodule // dopwm_top

// file: dopwm_pkg.sv
// Contract
// - Mode 0: no waveform, pins stay ports
// - Mode 1: compare B sets period
// - Mode 1: compare A sets duty
// - Mode 2: twin outputs, 8-bit resolution max
// - Mode 2: compare B low byte sets period
// - Mode 2: out A low at A-low match
// - Mode 2: out B high B-high, low A-high
// - Mode 2: B-high zero starts both together
// - Mode 3: counter runs full 16-bit range
// - Mode 3: out A high below compare A
// - Mode 3: out B high below compare B
// - Mode 3: outputs with nonzero compare high at wrap
// - Mode 3: counter advances every clock
package dopwm_pkg;

  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;

  typedef enum logic [3:0] {
    DOPWM_M_OFF  = 4'b0001,
    DOPWM_M_ONE  = 4'b0010,
    DOPWM_M_TWIN = 4'b0100,
    DOPWM_M_FULL = 4'b1000
  } dopwm_mode_e;

  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_ONE  = 2'h1;
  localparam logic [1:0] MODE_TWIN = 2'h2;
  localparam logic [1:0] MODE_FULL = 2'h3;

  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [1:0]  MODE_RST = 2'h0;

  // Informational: 16 MHz core gives about 244 Hz in full mode
  localparam int REF_CLK_HZ = 16_000_000;
  localparam int CLK_HZ     = 50_000_000;

endpackage

// file: dopwm_mode_dec.sv
`timescale 1ns/10ps
// Maps the two-bit software field onto a one-hot mode
module dopwm_mode_dec (
  input  wire logic [1:0]          mode_i,   // Software mode field
  output dopwm_pkg::dopwm_mode_e   mode_o    // One-hot mode
);

  // Plain decode, default keeps the pins released
  always_comb begin
    case (mode_i)
      dopwm_pkg::MODE_ONE:  mode_o = dopwm_pkg::DOPWM_M_ONE;
      dopwm_pkg::MODE_TWIN: mode_o = dopwm_pkg::DOPWM_M_TWIN;
      dopwm_pkg::MODE_FULL: mode_o = dopwm_pkg::DOPWM_M_FULL;
      default:              mode_o = dopwm_pkg::DOPWM_M_OFF;
    endcase
  end

endmodule // dopwm_mode_dec

// file: dopwm_pin_mux.sv
`timescale 1ns/10ps
// Selects between waveform and ordinary port drive for one pin
module dopwm_pin_mux (
  input  wire logic pwm_en_i,    // Waveform owns the pin
  input  wire logic wave_i,      // Registered waveform level
  input  wire logic port_do_i,   // Port data from software
  input  wire logic port_oe_i,   // Port drive enable from software
  output logic      pin_o,       // Pin output level
  output logic      pin_oe_o     // Pin output enable
);

  // Waveform drives hard whenever enabled
  always_comb begin
    pin_o    = pwm_en_i ? wave_i : port_do_i;
    pin_oe_o = pwm_en_i | port_oe_i;
  end

endmodule // dopwm_pin_mux

// file: dopwm_checker.sv
`timescale 1ns/10ps
// Ties counter and both waveforms to the mode and compare inputs
module dopwm_checker (
  input wire logic        clk_i,                 // Clock
  input wire logic        arst_n_i,              // Reset
  input wire logic [1:0]  mode_i,                // Mode
  input wire logic [7:0]  compare_a_high_byte_i, // A high
  input wire logic [7:0]  compare_a_low_byte_i,  // A low
  input wire logic [7:0]  compare_b_high_byte_i, // B high
  input wire logic [7:0]  compare_b_low_byte_i,  // B low
  input wire logic        port_a_do_i,           // Port data A
  input wire logic        port_a_oe_i,           // Port enable A
  input wire logic        port_pin_a_o,          // Pin A
  input wire logic        port_pin_a_oe_o,       // Pin A enable
  input wire logic [15:0] count_o,               // Counter
  input wire logic        waveform_out_a_o,      // Wave A
  input wire logic        waveform_out_b_o,      // Wave B
  input wire logic        active_o               // Mode on
);
  // Compare pairs as the counter sees them
  wire logic [15:0] ca = {compare_a_high_byte_i, compare_a_low_byte_i};
  wire logic [15:0] cb = {compare_b_high_byte_i, compare_b_low_byte_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Six steady samples step over the double restart of a mode change
  sequence s_st(logic [1:0] m);
    (mode_i == m && $stable(ca) && $stable(cb)) [*6];
  endsequence
  property p_off_idle; !(active_o || $past(active_o) || $past(active_o, 2)) |->
    count_o == 16'h0000 && !waveform_out_a_o && !waveform_out_b_o; endproperty
  a_off_idle: assert property (p_off_idle) else $error("busy in mode 0");
  property p_off_pin; !active_o |->
    port_pin_a_o == port_a_do_i && port_pin_a_oe_o == port_a_oe_i; endproperty
  a_off_pin: assert property (p_off_pin) else $error("pin not ported");
  property p_one_wrap; s_st(2'h1) ##0 count_o == cb |=> count_o == 16'h0000; endproperty
  a_one_wrap: assert property (p_one_wrap) else $error("no wrap at period");
  property p_one_duty; s_st(2'h1) |-> waveform_out_a_o == (count_o < ca); endproperty
  a_one_duty: assert property (p_one_duty) else $error("duty wrong");
  property p_twin_a; s_st(2'h2) |-> waveform_out_a_o == (count_o < {8'h00, compare_a_low_byte_i})
    && count_o <= {8'h00, compare_b_low_byte_i}; endproperty
  a_twin_a: assert property (p_twin_a) else $error("twin A wrong");
  property p_twin_b; s_st(2'h2) |-> (count_o == {8'h00, compare_a_high_byte_i}) ?
    !waveform_out_b_o : (count_o == {8'h00, compare_b_high_byte_i}) ? waveform_out_b_o : 1'b1;
  endproperty
  a_twin_b: assert property (p_twin_b) else $error("twin B edge wrong");
  property p_full_step; s_st(2'h3) |-> count_o == $past(count_o) + 16'h0001; endproperty
  a_full_step: assert property (p_full_step) else $error("count skipped");
  property p_full_wave; s_st(2'h3) |-> waveform_out_a_o == (count_o < ca) &&
    waveform_out_b_o == (count_o < cb); endproperty
  a_full_wave: assert property (p_full_wave) else $error("full wave wrong");
endmodule // dopwm_checker
bind dopwm_top dopwm_checker u_chk (.*);

// file: dopwm_load.sv
`timescale 1ns/10ps
// Load on one pin: follows the pin while driven
module dopwm_load (
  input  wire logic clk_i, // Clock
  input  wire logic pin_i, // Pin level
  input  wire logic oe_i,  // Pin driven
  output logic      lvl_o  // Wire level
);
  logic flt_r = 1'b0;
  // No pull on the wire, so an undriven pin wanders each cycle
  always_ff @(posedge clk_i) flt_r <= ~flt_r;
  assign lvl_o = oe_i ? pin_i : flt_r;
endmodule // dopwm_load

// file: dopwm_tb_top.sv
`timescale 1ns/10ps
// Random compares per mode against an integer counter model
module dopwm_tb_top;
  logic        clk_i = 1'b0, arst_n_i = 1'b0, la, lb, pao, paoe, pbo, pboe, wa, wb;
  logic [1:0]  mode_i = 2'h0;
  logic [15:0] ca = 16'h0000, cb = 16'h0000, cnt;
  logic [3:0]  pt = 4'h0;
  int          mismatches = 0, n_compared = 0;
  initial begin forever #10 clk_i = ~clk_i; end
  dopwm_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .mode_i(mode_i),
    .compare_a_high_byte_i(ca[15:8]), .compare_a_low_byte_i(ca[7:0]),
    .compare_b_high_byte_i(cb[15:8]), .compare_b_low_byte_i(cb[7:0]),
    .port_a_do_i(pt[0]), .port_a_oe_i(pt[1]), .port_b_do_i(pt[2]), .port_b_oe_i(pt[3]),
    .port_pin_a_i(la), .port_pin_b_i(lb), .port_pin_a_o(pao), .port_pin_a_oe_o(paoe),
    .port_pin_b_o(pbo), .port_pin_b_oe_o(pboe), .port_pin_a_sync_o(), .port_pin_b_sync_o(),
    .count_o(cnt), .waveform_out_a_o(wa), .waveform_out_b_o(wb), .active_o());
  dopwm_load u_la (.clk_i(clk_i), .pin_i(pao), .oe_i(paoe), .lvl_o(la));
  dopwm_load u_lb (.clk_i(clk_i), .pin_i(pbo), .oe_i(pboe), .lvl_o(lb));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Program, wait for count 1 (three cycles in mode 0), then model each cycle
  task automatic run(input logic [1:0] md, input logic [15:0] a, b, input int n);
    int m = 1, k = 0, p;
    bit eb = 0, vb = 0, ea;
    p = (md == 2'h1) ? int'(b) : (md == 2'h2) ? int'(b[7:0]) : 65535;
    @(posedge clk_i);
    mode_i <= md;
    ca <= a;
    cb <= b;
    @(negedge clk_i);
    if (md == 2'h0) repeat (3) @(negedge clk_i);
    else while (cnt !== 16'h0001 && k < 70000) begin @(negedge clk_i); k++; end
    repeat (n) begin
      ea = (md == 2'h2) ? m < int'(a[7:0]) : md != 2'h0 && m < int'(a);
      if (md == 2'h2 && m == int'(a[15:8])) {vb, eb} = 2'b10;
      else if (md == 2'h2 && m == int'(b[15:8])) {vb, eb} = 2'b11;
      cmp(cnt, (md == 2'h0) ? 16'h0 : 16'(m));
      cmp(16'(wa), 16'(ea));
      if (md != 2'h2 || vb) cmp(16'(wb), 16'(md == 2'h3 ? m < int'(b) : eb));
      cmp(16'({pao, paoe}), 16'(md == 2'h0 ? {pt[0], pt[1]} : {ea, 1'b1}));
      m = (m >= p) ? 0 : m + 1;
      @(posedge clk_i) pt <= 4'($urandom);
      @(negedge clk_i);
    end
  endtask
  initial begin
    int md, x;
    logic [15:0] a, b;
    void'($urandom(32'hcdef1037));
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      md = (i < 2) ? 1 : (i < 4) ? 2 : 3;
      x = 5 + $urandom % 40;
      a = 16'($urandom % (x + 3));
      b = 16'(x);
      if (md == 2) b[15:8] = (i == 3) ? 8'h00 : 8'($urandom % x);
      if (md == 2) a[15:8] = 8'($urandom % x);
      if (md == 3) {a, b} = {16'($urandom), 16'($urandom)};
      run(2'h0, 16'h0000, 16'h0000, 12);
      run(2'(md), a, b, (md == 3) ? 65540 : 3 * x + 3);
    end
    print_verdict();
  end
  // Cuts a hang short well past the full-range scenario
  initial begin
    #2_000_000;
    mismatches++;
    print_verdict();
  end
endmodule // dopwm_tb_top
